//--- pkg/ptsc_defs.svh
// Constants of the pixel tone and sharpening block
`ifndef PTSC_DEFS_SVH
`define PTSC_DEFS_SVH
`define PTSC_PIX_W 10
`define PTSC_PIX_MAX 10'h3FF
`define PTSC_PIX_HALF 10'h200
`define PTSC_THR_MAX 10'h100
`define PTSC_SUM_W 34
`define PTSC_GAIN_DB_MAX 5'h18
`define PTSC_GAIN_DB_RST 5'h00
`define PTSC_BLK_RST 10'h000
`define PTSC_RATIO_ONE 10'h100
`define PTSC_RATIO_MIN 10'h001
`define PTSC_RATIO_MAX 10'h3FF
`define PTSC_GAMMA_RST 8'h40
`define PTSC_GAMMA_FRAC 6
`define PTSC_SHARP_RST 8'h20
`define PTSC_SHARP_MIN 8'hF0
`define PTSC_SHARP_MAX 8'h7F
`define PTSC_SHARP_FRAC 4
`define PTSC_THR_RST 10'h010
`define PTSC_PCT_MUL 25'h0006400
`endif

//--- pkg/ptsc_pkg.sv
// Types of the pixel tone and sharpening block
package ptsc_pkg;
    typedef enum logic [1:0] {PTSC_AUTO_OFF, PTSC_AUTO_ONCE, PTSC_AUTO_CONT}
        ptsc_auto_t;
    typedef enum logic [1:0] {PTSC_BLK_ALL, PTSC_BLK_ANALOG, PTSC_BLK_DIGITAL}
        ptsc_blk_sel_t;
    typedef enum logic {PTSC_RATIO_RED, PTSC_RATIO_BLUE} ptsc_ratio_sel_t;
    typedef enum logic {PTSC_GAIN_ALL} ptsc_gain_sel_t;
    // One frame's worth of processing settings
    typedef struct packed {
        logic [4:0] gain_db;
        logic [9:0] blk_raw;
        logic clamp_en;
        logic [9:0] ratio_red;
        logic [9:0] ratio_blue;
        logic gamma_en;
        logic [7:0] gamma;
        logic sharp_en;
        logic sharp_auto;
        logic [7:0] sharp_amt;
        logic [9:0] sharp_thr;
    } ptsc_cfg_t;
endpackage : ptsc_pkg

//--- pkg/ptsc_stream_if.sv
// Valid/ready word stream between the pixel core and its output buffer
`timescale 1ns/1ps
interface ptsc_stream_if #(parameter int WIDTH = 12);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ptsc_stream_if

//--- rtl/ptsc_buf.sv
// Two-entry skid buffer: no word is lost when the receiver stalls
`timescale 1ns/1ps
module ptsc_buf #(
    parameter int WIDTH = 12
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    ptsc_stream_if.snk up,
    output logic [WIDTH-1:0] data_out,
    output logic valid_out,
    input wire logic ready_in
);
    logic [WIDTH-1:0] head_r;
    logic [WIDTH-1:0] skid_r;
    logic head_v_r;
    logic skid_v_r;
    wire head_free = !head_v_r || ready_in;

    // Ready depends on the skid slot alone, so it is a pure flop
    assign up.ready = !skid_v_r;
    assign data_out = head_r;
    assign valid_out = head_v_r;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            head_r <= '0;
            skid_r <= '0;
            head_v_r <= 1'b0;
            skid_v_r <= 1'b0;
        end
        else if (head_free)
        begin
            head_v_r <= skid_v_r || up.valid;
            head_r <= skid_v_r ? skid_r : up.data;
            skid_v_r <= 1'b0;
        end
        else if (up.valid && !skid_v_r)
        begin
            skid_v_r <= 1'b1;
            skid_r <= up.data;
        end
    end
endmodule : ptsc_buf

//--- rtl/ptsc_top.sv
// Pixel tone path: black level, gain, white balance, sharpening, gamma
`timescale 1ns/1ps
`include "ptsc_defs.svh"
module ptsc_top import ptsc_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [9:0] pix_in,
    input wire logic pix_sof_in,
    input wire logic pix_eol_in,
    input wire logic pix_valid_in,
    output logic pix_ready_out,
    output logic [9:0] pix_out,
    output logic pix_sof_out,
    output logic pix_eol_out,
    output logic pix_valid_out,
    input wire logic pix_ready_in,
    input wire logic gain_wr_in,
    input wire ptsc_gain_sel_t gain_sel_in,
    input wire logic [4:0] gain_db_in,
    input wire logic gain_auto_wr_in,
    input wire ptsc_auto_t gain_auto_in,
    input wire logic blk_wr_in,
    input wire ptsc_blk_sel_t blk_sel_in,
    input wire logic [9:0] blk_raw_in,
    input wire logic clamp_en_in,
    input wire logic ratio_wr_in,
    input wire ptsc_ratio_sel_t ratio_sel_in,
    input wire logic [9:0] ratio_in,
    input wire logic wb_auto_wr_in,
    input wire ptsc_auto_t wb_auto_in,
    input wire logic tone_wr_in,
    input wire logic gamma_en_in,
    input wire logic [7:0] gamma_in,
    input wire logic sharp_wr_in,
    input wire logic sharp_en_in,
    input wire logic sharp_auto_in,
    input wire logic [7:0] sharp_amt_in,
    input wire logic [9:0] sharp_thr_in,
    output logic [4:0] gain_db_out,
    output ptsc_auto_t gain_auto_out,
    output ptsc_auto_t wb_auto_out,
    output logic [9:0] ratio_out,
    output logic [9:0] blk_raw_out,
    output logic [15:0] blk_pct_out,
    output logic [9:0] sharp_thr_out
);
    // --------------------------------------------------------------
    // Settings: host copy and the copy the current frame uses
    // --------------------------------------------------------------
    ptsc_cfg_t pend_r;
    ptsc_cfg_t act_r;
    ptsc_auto_t gain_mode_r;
    ptsc_auto_t wb_mode_r;
    ptsc_stream_if #(.WIDTH(12)) core ();

    wire accept = pix_valid_in && core.ready;
    wire frame_start = accept && pix_sof_in;
    logic seen_r;
    wire frame_end = frame_start && seen_r;

    // Statistics of the frame in flight, judged at the next start
    logic [9:0] fmax_r;
    logic [9:0] fmin_r;
    logic [9:0] dark_r;
    logic [9:0] noise_r;
    logic [9:0] noise_frame_r;
    logic [`PTSC_SUM_W-1:0] sum_r_r;
    logic [`PTSC_SUM_W-1:0] sum_g_r;
    logic [`PTSC_SUM_W-1:0] sum_b_r;
    logic odd_col_r;
    logic odd_row_r;
    logic [9:0] hist1_r;
    logic [9:0] hist2_r;

    wire gain_auto_step = frame_end && gain_mode_r != PTSC_AUTO_OFF;
    wire gain_up = fmax_r < `PTSC_PIX_HALF &&
        pend_r.gain_db < `PTSC_GAIN_DB_MAX;
    wire gain_down = fmax_r == `PTSC_PIX_MAX && pend_r.gain_db != 5'h00;
    wire wb_auto_step = frame_end && wb_mode_r != PTSC_AUTO_OFF;
    // Green sites are twice as many as red or blue sites
    wire [`PTSC_SUM_W:0] sum_r2 = {sum_r_r, 1'b0};
    wire [`PTSC_SUM_W:0] sum_b2 = {sum_b_r, 1'b0};
    wire [`PTSC_SUM_W:0] sum_g1 = {1'b0, sum_g_r};
    wire red_lo = sum_r2 < sum_g1 && pend_r.ratio_red != `PTSC_RATIO_MAX;
    wire red_hi = sum_r2 > sum_g1 && pend_r.ratio_red != `PTSC_RATIO_MIN;
    wire blue_lo = sum_b2 < sum_g1 && pend_r.ratio_blue != `PTSC_RATIO_MAX;
    wire blue_hi = sum_b2 > sum_g1 && pend_r.ratio_blue != `PTSC_RATIO_MIN;
    wire [4:0] gain_wr_val = gain_db_in > `PTSC_GAIN_DB_MAX ?
        `PTSC_GAIN_DB_MAX : gain_db_in;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pend_r <= '{gain_db: `PTSC_GAIN_DB_RST, blk_raw: `PTSC_BLK_RST,
                clamp_en: 1'b0, ratio_red: `PTSC_RATIO_ONE,
                ratio_blue: `PTSC_RATIO_ONE, gamma_en: 1'b0,
                gamma: `PTSC_GAMMA_RST, sharp_en: 1'b0, sharp_auto: 1'b0,
                sharp_amt: `PTSC_SHARP_RST, sharp_thr: `PTSC_THR_RST};
            gain_mode_r <= PTSC_AUTO_OFF;
            wb_mode_r <= PTSC_AUTO_OFF;
        end
        else
        begin
            if (gain_auto_step && gain_up)
                pend_r.gain_db <= pend_r.gain_db + 5'h01;
            else if (gain_auto_step && gain_down)
                pend_r.gain_db <= pend_r.gain_db - 5'h01;
            if (gain_wr_in && gain_sel_in == PTSC_GAIN_ALL)
                pend_r.gain_db <= gain_wr_val;
            if (gain_auto_wr_in)
                gain_mode_r <= gain_auto_in;
            else if (gain_auto_step && gain_mode_r == PTSC_AUTO_ONCE)
                gain_mode_r <= PTSC_AUTO_OFF;
            if (blk_wr_in && blk_sel_in == PTSC_BLK_ALL)
                pend_r.blk_raw <= blk_raw_in;
            if (wb_auto_step && red_lo)
                pend_r.ratio_red <= pend_r.ratio_red + 10'h001;
            else if (wb_auto_step && red_hi)
                pend_r.ratio_red <= pend_r.ratio_red - 10'h001;
            if (wb_auto_step && blue_lo)
                pend_r.ratio_blue <= pend_r.ratio_blue + 10'h001;
            else if (wb_auto_step && blue_hi)
                pend_r.ratio_blue <= pend_r.ratio_blue - 10'h001;
            if (ratio_wr_in && ratio_sel_in == PTSC_RATIO_RED)
                pend_r.ratio_red <= ratio_in;
            if (ratio_wr_in && ratio_sel_in == PTSC_RATIO_BLUE)
                pend_r.ratio_blue <= ratio_in;
            if (wb_auto_wr_in)
                wb_mode_r <= wb_auto_in;
            else if (wb_auto_step && wb_mode_r == PTSC_AUTO_ONCE)
                wb_mode_r <= PTSC_AUTO_OFF;
            if (tone_wr_in)
            begin
                pend_r.clamp_en <= clamp_en_in;
                pend_r.gamma_en <= gamma_en_in;
                pend_r.gamma <= gamma_in;
            end
            if (sharp_wr_in)
            begin
                pend_r.sharp_en <= sharp_en_in;
                pend_r.sharp_auto <= sharp_auto_in;
                pend_r.sharp_amt <= sharp_amt_in;
                pend_r.sharp_thr <= sharp_thr_in;
            end
        end
    end

    // --------------------------------------------------------------
    // Pixel arithmetic, all combinational on the accepted pixel
    // --------------------------------------------------------------
    wire odd_col = pix_sof_in ? 1'b0 : odd_col_r;
    wire odd_row = pix_sof_in ? 1'b0 : odd_row_r;
    wire site_red = !odd_row && !odd_col;
    wire site_blue = odd_row && odd_col;
    wire ptsc_cfg_t cfg = pix_sof_in ? pend_r : act_r;

    // Black level offset, with optional dark current removal
    wire [9:0] dark_sub = cfg.clamp_en ? dark_r : 10'h000;
    wire signed [12:0] blk_sum = $signed({3'b000, pix_in}) -
        $signed({3'b000, dark_sub}) + $signed({3'b000, cfg.blk_raw});
    wire [9:0] blk_pix = blk_sum < 0 ? 10'h000 :
        blk_sum > 13'sh03FF ? `PTSC_PIX_MAX : blk_sum[9:0];

    // dB to linear: 2^(dB/6) as a Q8 fraction shifted by whole octaves
    logic [12:0] gain_lin;
    wire [2:0] gain_oct = 3'(cfg.gain_db / 5'h06);
    wire [2:0] gain_step = 3'(cfg.gain_db % 5'h06);
    always_comb
    begin
        case (gain_step)
            3'h0: gain_lin = 13'h0100;
            3'h1: gain_lin = 13'h011F;
            3'h2: gain_lin = 13'h0143;
            3'h3: gain_lin = 13'h016A;
            3'h4: gain_lin = 13'h0196;
            default: gain_lin = 13'h01C8;
        endcase
    end
    wire [12:0] gain_scale = gain_lin << gain_oct;
    wire [22:0] gain_prod = 23'(blk_pix) * 23'(gain_scale);
    wire [9:0] gain_pix = gain_prod[22:18] != 5'h00 ? `PTSC_PIX_MAX :
        gain_prod[17:8];

    // Colour ratios relative to green, Q2.8
    wire [9:0] ratio = site_red ? cfg.ratio_red :
        site_blue ? cfg.ratio_blue : `PTSC_RATIO_ONE;
    wire [19:0] wb_prod = 20'(gain_pix) * 20'(ratio);
    wire [9:0] wb_pix = wb_prod[19:18] != 2'h0 ? `PTSC_PIX_MAX :
        wb_prod[17:8];

    // Sharpening against the two previous pixels of the line
    wire signed [11:0] nb_avg = $signed({2'b00, 10'((11'(hist1_r) +
        11'(hist2_r)) >> 1)});
    wire signed [11:0] diff = $signed({2'b00, wb_pix}) - nb_avg;
    wire [11:0] abs_diff = diff < 0 ? 12'(-diff) : 12'(diff);
    wire [9:0] thr_raw = cfg.sharp_auto ? noise_frame_r :
        cfg.sharp_thr;
    wire [9:0] thr_eff = thr_raw > `PTSC_THR_MAX ? `PTSC_THR_MAX :
        thr_raw;
    wire signed [7:0] amt_raw = $signed(cfg.sharp_amt);
    wire signed [7:0] amt = amt_raw < $signed(`PTSC_SHARP_MIN) ?
        $signed(`PTSC_SHARP_MIN) : amt_raw > $signed(`PTSC_SHARP_MAX) ?
        $signed(`PTSC_SHARP_MAX) : amt_raw;
    wire signed [19:0] corr = (20'(diff) * 20'(amt)) >>>
        `PTSC_SHARP_FRAC;
    wire sharp_hit = cfg.sharp_en && !pix_sof_in &&
        abs_diff > 12'(thr_eff);
    wire signed [19:0] sharp_sum = $signed({10'h000, wb_pix}) + corr;
    wire [9:0] sharp_pix = !sharp_hit ? wb_pix :
        sharp_sum < 0 ? 10'h000 :
        sharp_sum > 20'sh003FF ? `PTSC_PIX_MAX : sharp_sum[9:0];

    // Gamma as 2^(gamma * log2 p) with piecewise-linear log and exp
    logic [3:0] msb;
    always_comb
    begin
        msb = 4'h0;
        for (int i = 0; i < 10; i++)
            if (sharp_pix[i])
                msb = 4'(i);
    end
    wire [9:0] mant = sharp_pix << (4'h9 - msb);
    wire signed [25:0] g_log = $signed({22'h0, msb} - 26'h00000A) * 26'sh400
        + $signed({15'h0, mant[8:0], 1'b0});
    wire signed [25:0] g_prod = (g_log * $signed({18'h0, cfg.gamma}))
        >>> `PTSC_GAMMA_FRAC;
    wire signed [25:0] g_neg = -(g_prod >>> 10);
    wire [10:0] g_lin = {1'b1, g_prod[9:0]};
    wire [10:0] g_exp = g_neg > 26'sd11 ? 11'h000 : g_lin >> g_neg[3:0];
    wire [9:0] gam_pix = sharp_pix == 10'h000 ? 10'h000 :
        g_exp[10] ? `PTSC_PIX_MAX : g_exp[9:0];
    wire [9:0] out_pix = cfg.gamma_en ? gam_pix : sharp_pix;

    assign core.valid = pix_valid_in;
    assign core.data = {pix_eol_in, pix_sof_in, out_pix};

    // --------------------------------------------------------------
    // Frame position, history and statistics
    // --------------------------------------------------------------
    wire [9:0] abs_d10 = abs_diff > 12'h3FF ? `PTSC_PIX_MAX : abs_diff[9:0];

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            act_r <= '{gain_db: `PTSC_GAIN_DB_RST, blk_raw: `PTSC_BLK_RST,
                clamp_en: 1'b0, ratio_red: `PTSC_RATIO_ONE,
                ratio_blue: `PTSC_RATIO_ONE, gamma_en: 1'b0,
                gamma: `PTSC_GAMMA_RST, sharp_en: 1'b0, sharp_auto: 1'b0,
                sharp_amt: `PTSC_SHARP_RST, sharp_thr: `PTSC_THR_RST};
            seen_r <= 1'b0;
            odd_col_r <= 1'b0;
            odd_row_r <= 1'b0;
            hist1_r <= '0;
            hist2_r <= '0;
            fmax_r <= '0;
            fmin_r <= `PTSC_PIX_MAX;
            dark_r <= '0;
            noise_r <= '0;
            noise_frame_r <= '0;
            sum_r_r <= '0;
            sum_g_r <= '0;
            sum_b_r <= '0;
        end
        else if (accept)
        begin
            if (pix_sof_in)
            begin
                act_r <= pend_r;
                seen_r <= 1'b1;
            end
            if (frame_end)
            begin
                dark_r <= fmin_r;
                noise_frame_r <= noise_r;
            end
            odd_col_r <= pix_eol_in ? 1'b0 : !odd_col;
            odd_row_r <= pix_eol_in ? !odd_row : odd_row;
            // A line start has no left neighbours: seed with itself
            hist1_r <= pix_eol_in ? 10'h000 : wb_pix;
            hist2_r <= pix_eol_in ? 10'h000 :
                (pix_sof_in || odd_col == 1'b0 && hist1_r == 10'h000) ?
                wb_pix : hist1_r;
            fmax_r <= (pix_sof_in || gain_pix > fmax_r) ? gain_pix : fmax_r;
            fmin_r <= (pix_sof_in || pix_in < fmin_r) ? pix_in : fmin_r;
            if (abs_d10 > noise_r)
                noise_r <= noise_r + 10'h001;
            else if (abs_d10 < noise_r)
                noise_r <= noise_r - 10'h001;
            sum_r_r <= (pix_sof_in ? '0 : sum_r_r) +
                (site_red ? `PTSC_SUM_W'(wb_pix) : '0);
            sum_b_r <= (pix_sof_in ? '0 : sum_b_r) +
                (site_blue ? `PTSC_SUM_W'(wb_pix) : '0);
            sum_g_r <= (pix_sof_in ? '0 : sum_g_r) +
                (!site_red && !site_blue ? `PTSC_SUM_W'(wb_pix) : '0);
        end
    end

    // --------------------------------------------------------------
    // Status read-back
    // --------------------------------------------------------------
    wire [9:0] blk_analog = pend_r.blk_raw >> 1;
    wire [9:0] blk_digital = pend_r.blk_raw - blk_analog;
    wire [9:0] blk_sel_val = blk_sel_in == PTSC_BLK_ANALOG ? blk_analog :
        blk_sel_in == PTSC_BLK_DIGITAL ? blk_digital : pend_r.blk_raw;
    wire [24:0] pct_prod = 25'(blk_sel_val) * `PTSC_PCT_MUL;
    wire [9:0] thr_show = act_r.sharp_auto ? noise_frame_r : act_r.sharp_thr;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gain_db_out <= `PTSC_GAIN_DB_RST;
            gain_auto_out <= PTSC_AUTO_OFF;
            wb_auto_out <= PTSC_AUTO_OFF;
            ratio_out <= `PTSC_RATIO_ONE;
            blk_raw_out <= `PTSC_BLK_RST;
            blk_pct_out <= '0;
            sharp_thr_out <= `PTSC_THR_RST;
        end
        else
        begin
            gain_db_out <= pend_r.gain_db;
            gain_auto_out <= gain_mode_r;
            wb_auto_out <= wb_mode_r;
            ratio_out <= ratio_sel_in == PTSC_RATIO_BLUE ?
                pend_r.ratio_blue : pend_r.ratio_red;
            blk_raw_out <= blk_sel_val;
            blk_pct_out <= pct_prod[24:9];
            sharp_thr_out <= thr_show > `PTSC_THR_MAX ? `PTSC_THR_MAX :
                thr_show;
        end
    end

    // --------------------------------------------------------------
    // Output buffer
    // --------------------------------------------------------------
    ptsc_buf #(.WIDTH(12)) u_buf (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .up(core),
        .data_out({pix_eol_out, pix_sof_out, pix_out}),
        .valid_out(pix_valid_out),
        .ready_in(pix_ready_in)
    );
    assign pix_ready_out = core.ready;
endmodule : ptsc_top

//--- testbench/ptsc_checker.sv
// Port assertions for the pixel tone block
`timescale 1ns/1ps
module ptsc_checker import ptsc_pkg::*; (
    input wire logic sys_clk_in, rst_n_in, pix_valid_out, pix_ready_in,
    input wire logic pix_ready_out, pix_sof_out, pix_eol_out,
    input wire logic gain_wr_in, blk_wr_in,
    input wire logic [9:0] pix_out, blk_raw_in, blk_raw_out, sharp_thr_out,
    input wire logic [4:0] gain_db_in, gain_db_out,
    input wire logic [15:0] blk_pct_out,
    input wire ptsc_blk_sel_t blk_sel_in,
    input wire ptsc_auto_t gain_auto_out
);
    logic [24:0] pct_full;
    assign pct_full = {15'h0000, blk_raw_out} * 25'h0006400;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_out_hold: assert property (pix_valid_out && !pix_ready_in |=>
        pix_valid_out && $stable({pix_out, pix_sof_out, pix_eol_out}))
        else $error("output word changed during stall");
    a_skid_full: assert property (!pix_ready_out |-> pix_valid_out)
        else $error("input refused with no output word");
    a_skid_free: assert property
        (pix_valid_out && pix_ready_in && !pix_ready_out |=> pix_ready_out)
        else $error("input stayed refused after drain");
    a_gain_range: assert property (gain_db_out <= 5'h18)
        else $error("gain above limit");
    a_gain_write: assert property (
        gain_wr_in && gain_auto_out == PTSC_AUTO_OFF |-> ##2 gain_db_out ==
        ($past(gain_db_in, 2) > 5'h18 ? 5'h18 : $past(gain_db_in, 2)))
        else $error("gain write not applied");
    a_blk_write: assert property (
        blk_wr_in && blk_sel_in == PTSC_BLK_ALL ##1 blk_sel_in == PTSC_BLK_ALL
        |=> blk_raw_out == $past(blk_raw_in, 2))
        else $error("black level write not applied");
    a_blk_ro: assert property (
        ($stable(blk_sel_in) && blk_sel_in != PTSC_BLK_ALL) [*3]
        |-> $stable(blk_raw_out))
        else $error("read-only black level changed");
    a_pct_calc: assert property (blk_pct_out == pct_full[24:9])
        else $error("percent black level mismatch");
    a_thr_max: assert property (sharp_thr_out <= 10'h100)
        else $error("threshold above quarter range");
    c_stall: cover property (!pix_ready_out);
    c_sof: cover property (pix_valid_out && pix_sof_out);
    c_clamp: cover property (gain_wr_in && gain_db_in > 5'h18);
endmodule : ptsc_checker

bind ptsc_top ptsc_checker u_chk (.sys_clk_in, .rst_n_in, .pix_valid_out,
    .pix_ready_in, .pix_ready_out, .pix_sof_out, .pix_eol_out, .gain_wr_in,
    .blk_wr_in, .pix_out, .blk_raw_in, .blk_raw_out, .sharp_thr_out,
    .gain_db_in, .gain_db_out, .blk_pct_out, .blk_sel_in, .gain_auto_out);

//--- testbench/ptsc_sensor.sv
// Sensor readout model feeding pixels under valid and ready
`timescale 1ns/1ps
module ptsc_sensor (
    input wire logic sys_clk_in,
    input wire logic ready_in,
    output logic [9:0] pix_out,
    output logic sof_out,
    output logic eol_out,
    output logic valid_out
);
    initial
    begin
        {pix_out, sof_out, eol_out, valid_out} = '0;
    end
    // Ready is read at the falling edge, where the flop output is settled
    task automatic send_line(input logic [9:0] px [$], input logic first,
        output bit hung);
        bit ok;
        int n;
        hung = 0;
        @(posedge sys_clk_in);
        foreach (px[i])
        begin
            pix_out <= px[i];
            sof_out <= first && i == 0;
            eol_out <= i == px.size() - 1;
            valid_out <= 1'b1;
            n = 0;
            do
            begin
                @(negedge sys_clk_in);
                ok = ready_in;
                n++;
                @(posedge sys_clk_in);
            end while (!ok && n < 100);
            hung |= !ok;
        end
        valid_out <= 1'b0;
        pix_out <= ~px[px.size() - 1];
    endtask : send_line
endmodule : ptsc_sensor

//--- testbench/tb_pixel_tone_sharpen_control.sv
// Self-checking bench for the pixel tone block
`timescale 1ns/1ps
module tb_pixel_tone_sharpen_control import ptsc_pkg::*;;
    logic sys_clk_in = 1'b0;
    logic rst_n_in, pix_sof_in, pix_eol_in, pix_valid_in, pix_ready_in;
    logic pix_ready_out, pix_sof_out, pix_eol_out, pix_valid_out;
    logic gain_wr_in, gain_auto_wr_in, blk_wr_in, ratio_wr_in, wb_auto_wr_in;
    logic tone_wr_in, sharp_wr_in, clamp_en_in, gamma_en_in, sharp_en_in;
    logic sharp_auto_in;
    logic [9:0] pix_in, pix_out, blk_raw_in, ratio_in, sharp_thr_in;
    logic [9:0] ratio_out, blk_raw_out, sharp_thr_out;
    logic [7:0] gamma_in, sharp_amt_in;
    logic [4:0] gain_db_in, gain_db_out;
    logic [15:0] blk_pct_out;
    ptsc_gain_sel_t gain_sel_in;
    ptsc_auto_t gain_auto_in, wb_auto_in, gain_auto_out, wb_auto_out;
    ptsc_blk_sel_t blk_sel_in;
    ptsc_ratio_sel_t ratio_sel_in;
    logic [6:0] wr;
    logic [9:0] got [$];
    logic [9:0] edge_px [$] = '{10'h064, 10'h064, 10'h064, 10'h0C8};
    logic [9:0] dark [$] = '{10'h010, 10'h010, 10'h010, 10'h010};
    logic [9:0] mix [$] = '{10'h064, 10'h3FF, 10'h000, 10'h0C8, 10'h12C};
    logic [7:0] amt_t [6] = '{8'h20, 8'h10, 8'hF0, 8'hE0, 8'h00, 8'h20};
    logic [9:0] thr_t [6] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
        10'h080};
    logic [9:0] res_t [6] = '{10'h190, 10'h12C, 10'h064, 10'h064, 10'h0C8,
        10'h0C8};
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    assign {sharp_wr_in, tone_wr_in, wb_auto_wr_in, ratio_wr_in, blk_wr_in,
        gain_auto_wr_in, gain_wr_in} = wr;
    always #10 sys_clk_in = ~sys_clk_in;
    ptsc_top dut (.sys_clk_in, .rst_n_in, .pix_in, .pix_sof_in, .pix_eol_in,
        .pix_valid_in, .pix_ready_out, .pix_out, .pix_sof_out, .pix_eol_out,
        .pix_valid_out, .pix_ready_in, .gain_wr_in, .gain_sel_in, .gain_db_in,
        .gain_auto_wr_in, .gain_auto_in, .blk_wr_in, .blk_sel_in, .blk_raw_in,
        .clamp_en_in, .ratio_wr_in, .ratio_sel_in, .ratio_in, .wb_auto_wr_in,
        .wb_auto_in, .tone_wr_in, .gamma_en_in, .gamma_in, .sharp_wr_in,
        .sharp_en_in, .sharp_auto_in, .sharp_amt_in, .sharp_thr_in,
        .gain_db_out, .gain_auto_out, .wb_auto_out, .ratio_out, .blk_raw_out,
        .blk_pct_out, .sharp_thr_out);
    ptsc_sensor sensor (.sys_clk_in, .ready_in(pix_ready_out),
        .pix_out(pix_in), .sof_out(pix_sof_in), .eol_out(pix_eol_in),
        .valid_out(pix_valid_in));
    always @(posedge sys_clk_in)
    begin
        cyc <= cyc + 1;
        pix_ready_in <= (cyc % 3) != 0;
        if (pix_valid_out && pix_ready_in)
            got.push_back(pix_out);
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Strobe k is one cycle long; k of 7 only waits
    task automatic put(input int k);
        @(posedge sys_clk_in);
        wr <= 7'h01 << k;
        @(posedge sys_clk_in);
        wr <= 7'h00;
        repeat (3) @(posedge sys_clk_in);
    endtask : put
    // Mode 0 no compare, 1 last word, 2 every word unchanged
    task automatic frame(input logic [9:0] px [$], input logic first,
        input int mode, input logic [9:0] exp);
        bit hung;
        int n;
        got.delete();
        sensor.send_line(px, first, hung);
        n = 0;
        while (got.size() < px.size() && n < 200)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (hung || n == 200)
        begin
            fails++;
            end_sim();
        end
        if (mode == 1)
            chk("last pixel", got[$], exp);
        for (int i = 0; mode == 2 && i < px.size(); i++)
            chk("pass pixel", got[i], px[i]);
    endtask : frame
    initial
    begin
        gain_sel_in = PTSC_GAIN_ALL;
        gain_auto_in = PTSC_AUTO_OFF;
        wb_auto_in = PTSC_AUTO_OFF;
        blk_sel_in = PTSC_BLK_ALL;
        ratio_sel_in = PTSC_RATIO_RED;
        {rst_n_in, wr, gain_db_in, blk_raw_in, clamp_en_in,
            ratio_in, gamma_en_in, gamma_in, sharp_en_in, sharp_auto_in,
            sharp_amt_in, sharp_thr_in} = '0;
        repeat (20) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        put(7);
        chk("gain", gain_db_out, 5'h00);
        chk("gain auto", gain_auto_out, PTSC_AUTO_OFF);
        chk("wb auto", wb_auto_out, PTSC_AUTO_OFF);
        chk("ratio", ratio_out, 10'h100);
        chk("black", blk_raw_out, 10'h000);
        chk("threshold", sharp_thr_out, 10'h010);
        gain_db_in <= 5'h1F;
        put(0);
        chk("gain", gain_db_out, 5'h18);
        gain_db_in <= 5'h00;
        put(0);
        chk("gain", gain_db_out, 5'h00);
        blk_raw_in <= 10'h200;
        put(2);
        chk("black", blk_raw_out, 10'h200);
        chk("black pct", blk_pct_out, 16'h6400);
        blk_sel_in <= PTSC_BLK_ANALOG;
        blk_raw_in <= 10'h3FF;
        put(2);
        chk("analog", blk_raw_out, 10'h100);
        blk_sel_in <= PTSC_BLK_DIGITAL;
        put(2);
        chk("digital", blk_raw_out, 10'h100);
        blk_sel_in <= PTSC_BLK_ALL;
        blk_raw_in <= 10'h000;
        put(2);
        chk("black", blk_raw_out, 10'h000);
        ratio_in <= 10'h180;
        put(3);
        chk("red", ratio_out, 10'h180);
        ratio_sel_in <= PTSC_RATIO_BLUE;
        ratio_in <= 10'h080;
        put(3);
        chk("blue", ratio_out, 10'h080);
        ratio_in <= 10'h100;
        put(3);
        ratio_sel_in <= PTSC_RATIO_RED;
        put(3);
        chk("red", ratio_out, 10'h100);
        sharp_amt_in <= 8'h7F;
        sharp_thr_in <= 10'h3FF;
        put(6);
        put(5);
        frame(mix, 1, 2, 10'h000);
        chk("threshold", sharp_thr_out, 10'h100);
        for (int i = 0; i < 6; i++)
        begin
            sharp_en_in <= 1'b1;
            sharp_amt_in <= amt_t[i];
            sharp_thr_in <= thr_t[i];
            put(6);
            frame(edge_px, 1, 1, res_t[i]);
        end
        sharp_en_in <= 1'b0;
        sharp_thr_in <= 10'h000;
        put(6);
        frame(edge_px, 1, 1, 10'h0C8);
        sharp_en_in <= 1'b1;
        sharp_amt_in <= 8'h20;
        put(6);
        frame(edge_px, 0, 1, 10'h0C8);
        frame(edge_px, 1, 1, 10'h190);
        gamma_en_in <= 1'b1;
        gamma_in <= 8'h20;
        put(5);
        gain_auto_in <= PTSC_AUTO_ONCE;
        put(1);
        frame(dark, 1, 1, 10'h080);
        frame(dark, 1, 0, 10'h000);
        chk("gain auto", gain_auto_out, PTSC_AUTO_OFF);
        chk("gain", gain_db_out, 5'h01);
        gain_auto_in <= PTSC_AUTO_CONT;
        put(1);
        repeat (3) frame(dark, 1, 0, 10'h000);
        chk("gain auto", gain_auto_out, PTSC_AUTO_CONT);
        chk("gain", gain_db_out, 5'h04);
        wb_auto_in <= PTSC_AUTO_ONCE;
        put(4);
        frame(dark, 1, 0, 10'h000);
        frame(dark, 1, 0, 10'h000);
        chk("wb auto", wb_auto_out, PTSC_AUTO_OFF);
        chk("red", ratio_out, 10'h0FF);
        end_sim();
    end
endmodule : tb_pixel_tone_sharpen_control
